// file: rtl/dacc_top.sv
// Purpose: register interface and transfer control of one converter channel
// Assumes: apb slave, inputs synchronous to pclk
// Notes: instantiate twice for the two channels
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - no conversion before enable and startup
// - output register never writable by software
// - copy automatic or on trigger per mode
// - 8-bit mode shifts left two, zero lsbs
// - dma moves byte or half-word per sample
// - trigger off, each write starts conversion
// - trigger on, selected rising edge loads output
// - pending set while holding not yet moved
// - pending can raise the interrupt
// - two instances, each own interrupt line
// - eight registers, listed resets, write-only ones
// - no trigger, output one cycle after write
// - select codes 0 to 5, 11x reserved
// - right aligned, upper bits read zero
// - soft reset bit clears interface registers, not power sequence
module dacc_top
  import dacc_pkg::*;
(
  input wire logic pclk, // master clock
  input wire logic presetn, // async reset, active low
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_manager_en, // enable from power manager
  input wire logic [5:0] timer_wave_out, // timer trigger outputs
  output logic [1:0] dma_size, // 0 byte, 1 half-word
  output logic [9:0] conv_code, // code driven to the analog core
  output logic conv_load, // one-cycle output load strobe
  output logic conv_irq // interrupt to the controller
);
  import dacc_pkg::*;

  // state registers
  dacc_state_e state_q, state_d; // power sequence
  logic [5:0] warm_q; // startup countdown
  logic [4:0] mode_q; // mode_config bits
  logic [DATA_W-1:0] hold_q; // sample_holding
  logic [DATA_W-1:0] out_q; // sample_output
  logic pend_q; // sample_pending
  logic mask_q; // irq mask
  logic [5:0] trig_q; // last timer levels
  logic irq_q; // registered irq
  logic load_q; // load strobe register

  // bus decode
  wire acc = psel && penable; // access phase
  wire wr = acc && pwrite; // write commit
  wire hit_ctrl = (paddr == OFF_CTRL);
  wire hit_mode = (paddr == OFF_MODE);
  wire hit_hold = (paddr == OFF_HOLD);
  wire hit_out = (paddr == OFF_OUT);
  wire hit_flags = (paddr == OFF_FLAGS);
  wire hit_ien = (paddr == OFF_IEN);
  wire hit_idis = (paddr == OFF_IDIS);
  wire hit_imask = (paddr == OFF_IMASK);
  wire mapped = hit_ctrl | hit_mode | hit_hold | hit_out | hit_flags |
                hit_ien | hit_idis | hit_imask;
  // soft reset acts on the same cycle as its write
  wire soft_reset_bit = wr && hit_ctrl && pwdata[BIT_SOFT_RESET_BIT];
  wire hold_wr = wr && hit_hold;

  // mode fields
  wire trig_on = mode_q[BIT_TRGON];
  wire [SEL_W-1:0] sel = mode_q[BIT_SEL_LO +: SEL_W];
  wire res8 = mode_q[BIT_RES];
  wire sel_ok = (sel < 3'(NUM_TRIG));
  wire [NUM_TRIG-1:0] rise = timer_wave_out & ~trig_q;
  wire trig_hit = trig_on && sel_ok && rise[sel];

  // adjusted sample, 8-bit mode shifts left two
  wire [DATA_W-1:0] adj = res8 ? {pwdata[7:0], 2'b00} : pwdata[9:0];
  wire running = (state_q == ST_RUN);

  // buffer between holding and output stages
  logic buf_in_ready;
  logic buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;
  // fast path: direct write to output one cycle after write
  wire direct = hold_wr && !trig_on && running;
  // buffer only carries automatic-mode words; trigger mode loads
  // straight from holding so no stale word can follow a later edge
  // a fresh write replaces an unmoved pending word
  wire drain = running && !trig_on && !direct;
  wire push = pend_q && !trig_on && running && !hold_wr && buf_in_ready;
  wire trig_load = trig_hit && running && pend_q;

  dacc_skid #(.W(DATA_W)) u_skid (
    .pclk(pclk),
    .presetn(presetn),
    .clr(soft_reset_bit),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data(hold_q),
    .out_valid(buf_out_valid),
    .out_ready(drain),
    .out_data(buf_out_data)
  );

  // power sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: if (power_manager_en) state_d = ST_WARM;
      ST_WARM: if (!power_manager_en) state_d = ST_OFF;
               else if (warm_q == 6'd1) state_d = ST_RUN;
      ST_RUN: if (!power_manager_en) state_d = ST_OFF;
      default: state_d = ST_OFF;
    endcase
  end

  // sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_OFF;
      warm_q <= '0;
    end else begin
      state_q <= state_d;
      warm_q <= (state_q == ST_OFF) ? STARTUP_CNT :
                (warm_q != 6'd0) ? 6'(warm_q - 6'd1) : warm_q;
    end
  end

  // mode and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= '0;
      mask_q <= 1'b0;
    end else if (soft_reset_bit) begin
      mode_q <= '0;
      mask_q <= 1'b0;
    end else begin
      if (wr && hit_mode) mode_q <= pwdata[4:0] & MODE_MASK;
      if (wr && hit_ien && pwdata[BIT_PEND]) mask_q <= 1'b1;
      else if (wr && hit_idis && pwdata[BIT_PEND]) mask_q <= 1'b0;
    end
  end

  // holding register and pending flag; a new write wins over the move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= '0;
      pend_q <= 1'b0;
    end else if (soft_reset_bit) begin
      hold_q <= '0;
      pend_q <= 1'b0;
    end else if (hold_wr) begin
      hold_q <= adj;
      pend_q <= !direct;
    end else if (push || trig_load) begin
      pend_q <= 1'b0;
    end
  end

  // output register, only loaded by hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
      load_q <= 1'b0;
    end else if (soft_reset_bit) begin
      out_q <= '0;
      load_q <= 1'b0;
    end else if (direct) begin
      out_q <= adj;
      load_q <= 1'b1;
    end else if (trig_load) begin
      out_q <= hold_q;
      load_q <= 1'b1;
    end else if (buf_out_valid && drain) begin
      out_q <= buf_out_data;
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end

  // timer level history and irq register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= '0;
      irq_q <= 1'b0;
    end else begin
      trig_q <= timer_wave_out;
      irq_q <= pend_q && mask_q;
    end
  end

  // read mux
  wire [31:0] rd_mode = {27'h0, mode_q};
  wire [31:0] rd_hold = {22'h0, hold_q};
  wire [31:0] rd_out = {22'h0, out_q};
  wire [31:0] rd_flags = {31'h0, pend_q};
  wire [31:0] rd_imask = {31'h0, mask_q};
  assign prdata = !(acc && !pwrite) ? 32'h00000000 :
                  hit_mode ? rd_mode :
                  hit_hold ? rd_hold :
                  hit_out ? rd_out :
                  hit_flags ? rd_flags :
                  hit_imask ? rd_imask : 32'h00000000;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign dma_size = res8 ? 2'd0 : 2'd1;
  assign conv_code = out_q;
  assign conv_load = load_q;
  assign conv_irq = irq_q;

  // assertions
  property p_noload_cold;
    @(posedge pclk) disable iff (!presetn)
    !running |=> !conv_load;
  endproperty
  a_noload_cold: assert property (p_noload_cold) else $error("load while not running");
  property p_direct;
    @(posedge pclk) disable iff (!presetn)
    (hold_wr && !trig_on && running && !soft_reset_bit) |=> (out_q == $past(adj)) && conv_load;
  endproperty
  a_direct: assert property (p_direct) else $error("automatic move late");
  property p_out_ro;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_out && !direct && !trig_hit && !(buf_out_valid && drain)) |=> $stable(out_q);
  endproperty
  a_out_ro: assert property (p_out_ro) else $error("output written by bus");
  property p_res8;
    @(posedge pclk) disable iff (!presetn)
    (hold_wr && res8 && !soft_reset_bit) |=> hold_q[1:0] == 2'b00 && hold_q[9:2] == $past(pwdata[7:0]);
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit shift wrong");
  property p_trig;
    @(posedge pclk) disable iff (!presetn)
    (trig_hit && running && pend_q && !hold_wr && !soft_reset_bit) |=> out_q == $past(hold_q) && !pend_q;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger edge missed");
  property p_pend;
    @(posedge pclk) disable iff (!presetn)
    (hold_wr && trig_on && !soft_reset_bit) |=> pend_q;
  endproperty
  a_pend: assert property (p_pend) else $error("pending not set");
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (pend_q && mask_q) |=> conv_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  property p_mask;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_ien && pwdata[0] && !soft_reset_bit) |=> mask_q;
  endproperty
  a_mask: assert property (p_mask) else $error("enable did not set mask");
  property p_soft_reset_bit;
    @(posedge pclk) disable iff (!presetn)
    soft_reset_bit |=> mode_q == 5'h00 && !pend_q && !mask_q && out_q == 10'h000;
  endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset incomplete");
  property p_dma;
    @(posedge pclk) disable iff (!presetn)
    res8 |-> dma_size == 2'd0;
  endproperty
  a_dma: assert property (p_dma) else $error("dma size wrong");
  // reserved select codes never load the output
  property p_sel_resv;
    @(posedge pclk) disable iff (!presetn)
    (trig_on && !sel_ok) |=> !conv_load;
  endproperty
  a_sel_resv: assert property (p_sel_resv) else $error("reserved select loaded");
  // trigger mode loads only on a selected edge
  property p_trig_once;
    @(posedge pclk) disable iff (!presetn)
    (trig_on && !trig_hit) |=> !conv_load;
  endproperty
  a_trig_once: assert property (p_trig_once) else $error("load without edge");
  // running automatic mode drains a buffered word at once unless a direct write takes that cycle
  property p_auto_drain;
    @(posedge pclk) disable iff (!presetn)
    (running && !trig_on && buf_out_valid && !soft_reset_bit) |=> conv_load;
  endproperty
  a_auto_drain: assert property (p_auto_drain) else $error("buffered word stuck");
  // automatic write while running leaves nothing pending
  property p_pend_clr;
    @(posedge pclk) disable iff (!presetn)
    (hold_wr && !trig_on && running && !soft_reset_bit) |=> !pend_q;
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending after move");
  // powered down never jumps straight to running
  property p_off_run;
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_OFF) |=> !running;
  endproperty
  a_off_run: assert property (p_off_run) else $error("startup skipped");
  // startup counter live during warm-up
  property p_warm;
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_WARM) |-> (warm_q != 6'd0);
  endproperty
  a_warm: assert property (p_warm) else $error("warm-up count empty");
  // unmapped access flagged and reads zero
  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (acc && !mapped) |-> pslverr && (prdata == 32'h00000000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  // mapped access never errors
  property p_mapped_ok;
    @(posedge pclk) disable iff (!presetn)
    (acc && mapped) |-> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("error on mapped access");
  // sample reads keep the upper bits clear
  property p_upper_zero;
    @(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && (hit_hold || hit_out)) |-> (prdata[31:10] == 22'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper sample bits set");
  // mode register keeps what was written
  property p_mode_wr;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_mode) |=> (mode_q == $past(pwdata[4:0]));
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
  // disable write clears the mask
  property p_idis;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_idis && pwdata[BIT_PEND]) |=> !mask_q;
  endproperty
  a_idis: assert property (p_idis) else $error("disable did not clear mask");
  // interrupt drops once pending or mask is gone
  property p_irq_off;
    @(posedge pclk) disable iff (!presetn)
    !(pend_q && mask_q) |=> !conv_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without cause");
endmodule : dacc_top
`default_nettype wire

// file: rtl/dacc_pkg.sv
// Purpose: constants for the converter control block
// Assumes: 32-bit apb data, one word per register
// Notes: all offsets are byte addresses
package dacc_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00; // control_command
  localparam logic [7:0] OFF_MODE = 8'h04; // mode_config
  localparam logic [7:0] OFF_HOLD = 8'h08; // sample_holding
  localparam logic [7:0] OFF_OUT = 8'h0c; // sample_output
  localparam logic [7:0] OFF_FLAGS = 8'h10; // converter_flags
  localparam logic [7:0] OFF_IEN = 8'h14; // irq_enable_set
  localparam logic [7:0] OFF_IDIS = 8'h18; // irq_enable_clear
  localparam logic [7:0] OFF_IMASK = 8'h1c; // irq_mask_view
  localparam int BIT_SOFT_RESET_BIT = 0; // soft_reset_bit
  localparam int BIT_TRGON = 0; // timer_trigger_on
  localparam int BIT_SEL_LO = 1; // trigger_source_sel low bit
  localparam int BIT_RES = 4; // resolution_sel
  localparam int BIT_PEND = 0; // sample_pending
  localparam int DATA_W = 10; // sample width
  localparam int SEL_W = 3; // trigger select width
  localparam int NUM_TRIG = 6; // timer outputs
  localparam logic [4:0] MODE_MASK = 5'h1f; // writable mode bits
  localparam int CLK_MHZ = 10; // pclk rate
  localparam int STARTUP_US = 5; // longest startup
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ; // startup length in cycles, 5 us times 10 MHz = 50
  localparam logic [5:0] STARTUP_CNT = 6'(STARTUP_CYC); // counter load
  typedef enum logic [2:0] {
    ST_OFF = 3'b001, // power manager off
    ST_WARM = 3'b010, // startup running
    ST_RUN = 3'b100 // converting
  } dacc_state_e;
endpackage : dacc_pkg

// file: rtl/dacc_skid.sv
// Purpose: two-entry buffer between holding and output stage
// Assumes: synchronous clear from soft reset
// Notes: full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module dacc_skid #(
  parameter int W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2]; // entries
  logic wp_q; // write index
  logic rp_q; // read index
  logic [1:0] cnt_q; // fill level
  wire push = in_valid && in_ready; // accepted word
  wire pop = out_valid && out_ready; // drained word
  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rp_q];
  // pointers and level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'd0;
    end else if (clr) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      wp_q <= wp_q ^ push;
      rp_q <= rp_q ^ pop;
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end
  // storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule : dacc_skid
`default_nettype wire

// file: testbench/dacc_far_model.sv
// Purpose: far side model, analog core and timer trigger outputs
// Assumes: timer outputs change right after a rising pclk edge
// Notes: counts output loads and keeps the last loaded code
`timescale 1ns/1ps
`default_nettype none
module dacc_far_model (
  input wire logic pclk,
  input wire logic [9:0] conv_code,
  input wire logic conv_load,
  output logic [5:0] timer_wave_out
);
  int loads = 0; // loads seen by the analog core
  logic [9:0] last_code = 10'h000; // code taken at the last load
  initial timer_wave_out = 6'h00;
  // analog core takes the code on each load strobe
  always @(posedge pclk) begin
    if (conv_load === 1'b1) begin
      loads <= loads + 1;
      last_code <= conv_code;
    end
  end
  // timer in waveform mode: clean rise, held two cycles, then low
  task automatic pulse(input logic [5:0] m);
    @(posedge pclk);
    timer_wave_out <= m;
    repeat (2) @(posedge pclk);
    timer_wave_out <= 6'h00;
  endtask : pulse
endmodule : dacc_far_model
`default_nettype wire

// file: testbench/dacc_top_tb_top.sv
// Purpose: self-checking bench for one converter channel
// Assumes: zero-wait apb slave, pclk 10 MHz
// Notes: expectations come from the register map and mode rules
`timescale 1ns/1ps
`default_nettype none
module dacc_top_tb_top;
  import dacc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, power_manager_en; // bench driven
  logic [7:0] paddr; // apb address
  logic [31:0] pwdata, prdata, rdat; // apb data and last read
  logic pready, pslverr, rerr, conv_load, conv_irq; // design outputs and last error
  logic [5:0] timer_wave_out; // from the timer model
  logic [1:0] dma_size; // transfer size
  logic [9:0] conv_code; // code to the analog core
  int num_errors = 0;
  int checks_done = 0;
  int i, n; // loop index, load count snapshot
  dacc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_manager_en(power_manager_en),
    .timer_wave_out(timer_wave_out), .dma_size(dma_size), .conv_code(conv_code),
    .conv_load(conv_load), .conv_irq(conv_irq));
  dacc_far_model far (.pclk(pclk), .conv_code(conv_code), .conv_load(conv_load),
    .timer_wave_out(timer_wave_out));
  // verdict and end of run
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, setup then access until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int w; // wait count, kept apart from the load snapshot
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: no ready", $time);
      end_of_test();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  // free running clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    power_manager_en = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    rd(OFF_MODE, 32'h0); rd(OFF_HOLD, 32'h0); rd(OFF_OUT, 32'h0);
    rd(OFF_FLAGS, 32'h0); rd(OFF_IMASK, 32'h0);
    apb(1'b0, 8'h20, 32'h0); chk(rerr, 32'h1); chk(rdat, 32'h0);
    chk(dma_size, 32'h1);
    // powered down: no load; then startup and the word goes out
    wr(OFF_HOLD, 32'h155); repeat (10) @(posedge pclk); chk(far.loads, 32'h0);
    power_manager_en <= 1'b1;
    repeat (80) @(posedge pclk);
    chk(far.loads, 32'h1); chk(far.last_code, 32'h155);
    // trigger off: load one cycle after the write
    wr(OFF_HOLD, 32'h2aa); #1;
    chk(conv_load, 32'h1); chk(conv_code, 32'h2aa);
    rd(OFF_OUT, 32'h2aa); rd(OFF_FLAGS, 32'h0);
    wr(OFF_OUT, 32'h3ff); rd(OFF_OUT, 32'h2aa);
    wr(OFF_HOLD, 32'hfffff001); rd(OFF_HOLD, 32'h001);
    // mask on, every select code incl. both reserved ones
    wr(OFF_IEN, 32'h1); rd(OFF_IMASK, 32'h1);
    for (i = 0; i < 8; i++) begin
      wr(OFF_MODE, 32'(1 | (i << 1))); rd(OFF_MODE, 32'(1 | (i << 1)));
      n = far.loads;
      wr(OFF_HOLD, 32'h0f0);
      wr(OFF_HOLD, 32'(256 + i)); rd(OFF_FLAGS, 32'h1);
      chk(conv_irq, 32'h1);
      far.pulse((i < 6) ? 6'(1 << i) : 6'h3f);
      repeat (3) @(posedge pclk);
      chk(far.loads, 32'(n + ((i < 6) ? 1 : 0)));
      if (i < 6) chk(far.last_code, 32'(256 + i));
      rd(OFF_FLAGS, (i < 6) ? 32'h0 : 32'h1);
    end
    wr(OFF_IDIS, 32'h1); rd(OFF_IMASK, 32'h0); chk(conv_irq, 32'h0);
    // 8-bit mode shifts the sample and narrows the transfer
    wr(OFF_MODE, 32'h10); rd(OFF_MODE, 32'h10); chk(dma_size, 32'h0);
    wr(OFF_HOLD, 32'h0ff); rd(OFF_HOLD, 32'h3fc); rd(OFF_OUT, 32'h3fc);
    // soft reset: zero does nothing, one clears the interface
    wr(OFF_IEN, 32'h1); wr(OFF_CTRL, 32'h0); rd(OFF_MODE, 32'h10);
    wr(OFF_CTRL, 32'h1); rd(OFF_MODE, 32'h0); rd(OFF_HOLD, 32'h0);
    rd(OFF_OUT, 32'h0); rd(OFF_IMASK, 32'h0); chk(dma_size, 32'h1);
    end_of_test();
  end
endmodule : dacc_top_tb_top
`default_nettype wire
